// [shared/plane_fetch_pkg.sv]
/*
  Constants, types and helpers shared by the display plane fetch block.
  Assumes one 32-bit AXI4-Lite register window; byte address = 4 * register index.
*/
package plane_fetch_pkg;
  // register indices
  localparam logic [3:0] R_CTRL = 4'h0;
  localparam logic [3:0] R_SURF = 4'h1;
  localparam logic [3:0] R_STRIDE = 4'h2;
  localparam logic [3:0] R_OFFSET = 4'h3;
  localparam logic [3:0] R_SIZE = 4'h4;
  localparam logic [3:0] R_SHEIGHT = 4'h5;
  localparam logic [3:0] R_AUXDIST = 4'h6;
  localparam logic [3:0] R_AUXSTRIDE = 4'h7;
  localparam logic [3:0] R_CCVAL = 4'h8;
  localparam logic [3:0] R_PAGES = 4'h9;
  localparam logic [3:0] R_CUS = 4'hA;
  localparam logic [3:0] R_STATUS = 4'hB;
  localparam logic [3:0] R_LIVE = 4'hC;
  localparam logic [3:0] R_ID = 4'hD;
  localparam int NUM_DB = 10;
  localparam logic [31:0] REG_RESET = 32'h00000000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // 4K page holds 64 cache lines of 64 bytes
  localparam int PAGE_SHIFT = 12;
  localparam int LINE_SHIFT = 6;
  localparam logic [5:0] LAST_LINE = 6'h3F;
  localparam logic [11:0] PAGE_MASK = 12'hFFF;
  // command streamer numbering
  localparam int CS_CYCLED_PIPES = 3;
  localparam int CS_PIPE3_BASE = 21;

  typedef enum logic [2:0] {
    FMT_RGB2101010, FMT_RGB8888X, FMT_ARGB8888, FMT_XRBIAS,
    FMT_FP16, FMT_UINT16, FMT_RGB565, FMT_YUV
  } fmt_t;
  typedef enum logic [1:0] {TILE_LINEAR, TILE_X, TILE_Y, TILE_4} tile_t;
  typedef enum logic [1:0] {ROT_0, ROT_90, ROT_180, ROT_270} rot_t;

  typedef struct packed {
    logic [11:0] rsvd;
    logic tbPair;
    logic gammaEn;
    logic colorCorrEn;
    logic keyEn;
    logic hdr;
    logic fbcEn;
    logic clearEn;
    logic mediaDec;
    logic renderDec;
    logic asyncEn;
    logic interlace;
    logic mirror;
    rot_t rot;
    tile_t tile;
    fmt_t fmt;
    logic enable;
  } ctrl_t;

  typedef struct packed {
    logic [27:0] rsvd;
    logic [2:0] yBinding;
    logic enable;
  } cus_t;

  typedef struct packed {
    logic upsBad;
    logic auxAlignBad;
    logic mediaBad;
    logic renderBad;
    logic rotBad;
    logic interlaceBad;
    logic mirrorBad;
    logic hdrBad;
    logic asyncBad;
    logic fbcBad;
  } cap_err_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] csAddr;
    logic csNibble;
  } fetch_t;

  typedef struct packed {
    logic [31:0] stride;
    logic [31:0] offset;
    logic [31:0] size;
    logic [31:0] surfHeight;
    logic [31:0] auxStride;
    logic [31:0] clearColour;
  } geom_t;

  function automatic logic [5:0] cs_plane_num(input int pipe, input int plane);
    if (pipe < CS_CYCLED_PIPES) begin
      return 6'((plane - 1) * CS_CYCLED_PIPES + pipe + 1);
    end
    return 6'(CS_PIPE3_BASE + plane);
  endfunction : cs_plane_num
endpackage : plane_fetch_pkg

// [src/display_plane_yuv_decomp_fetch.sv]
/*
  One display plane: AXI4-Lite register file with armed double buffering,
  capability gating, chroma upsampler control and the frame fetch walker.
  Assumes vblankStart, tlbBoundary and dbStall come from the pipe, synchronous to ref_clk.
*/
`timescale 1ns/10ps
module display_plane_yuv_decomp_fetch #(
  parameter int PIPE = 0,
  parameter int PLANE = 1
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic vblankStart,
  input wire logic tlbBoundary,
  input wire logic dbStall,
  input wire logic yRoleIn,
  input wire logic fetchReady,
  output logic fetchValid,
  output plane_fetch_pkg::fetch_t fetchReq,
  output logic flipDone,
  output plane_fetch_pkg::ctrl_t planeCfg,
  output plane_fetch_pkg::geom_t planeGeom,
  output plane_fetch_pkg::cus_t upsCtl,
  output logic [2:0] postCtl
);
  localparam bit UV_PLANE = (PLANE >= 1) && (PLANE <= 3);
  localparam bit Y_PLANE = (PLANE == 4) || (PLANE == 5);
  localparam bit FBC_PLANE = (PIPE == 0) && (PLANE == 1);
  localparam logic [5:0] CS_NUM = plane_fetch_pkg::cs_plane_num(PIPE, PLANE);

  logic [31:0] pend_q [plane_fetch_pkg::NUM_DB];
  logic [31:0] act_q [plane_fetch_pkg::NUM_DB];
  logic [31:0] dbNext [plane_fetch_pkg::NUM_DB];
  plane_fetch_pkg::cus_t cus_q;
  logic [31:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic armed_q;
  logic startPend_q;
  plane_fetch_pkg::cap_err_t err;
  logic walkBusy;

  // write side decode
  wire logic doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire logic [3:0] wIdx = awAddr_q[5:2];
  wire logic wInRange = (awAddr_q[31:6] == 26'h0000000) && (wIdx <= plane_fetch_pkg::R_ID);
  wire logic wEn = doWrite && wInRange && (wIdx <= plane_fetch_pkg::R_CUS);
  wire logic [31:0] wMask = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
  wire logic [31:0] wOld = (wIdx == plane_fetch_pkg::R_CUS) ? cus_q : pend_q[wIdx];
  wire logic [31:0] wMerged = (wOld & ~wMask) | (wData_q & wMask);
  wire logic armWrite = wEn && (wIdx == plane_fetch_pkg::R_SURF);
  wire logic otherDbWrite = wEn && (wIdx < plane_fetch_pkg::R_CUS) && !armWrite;

  // programmed and committed views
  wire plane_fetch_pkg::ctrl_t ctrlP = pend_q[plane_fetch_pkg::R_CTRL];
  wire plane_fetch_pkg::ctrl_t ctrlA = act_q[plane_fetch_pkg::R_CTRL];
  plane_fetch_pkg::ctrl_t ctrlClean;

  plane_cap_check #(
    .PIPE(PIPE),
    .PLANE(PLANE)
  ) u_check (
    .ctrl(ctrlP),
    .cus(cus_q),
    .auxDist(pend_q[plane_fetch_pkg::R_AUXDIST]),
    .err(err)
  );

  // illegal feature requests are dropped at commit, the rest of the word passes
  always_comb begin
    ctrlClean = ctrlP;
    ctrlClean.fbcEn = ctrlP.fbcEn && !err.fbcBad;
    ctrlClean.asyncEn = ctrlP.asyncEn && !err.asyncBad;
    ctrlClean.hdr = ctrlP.hdr && !err.hdrBad;
    ctrlClean.mirror = ctrlP.mirror && !err.mirrorBad;
    ctrlClean.interlace = ctrlP.interlace && !err.interlaceBad && !err.rotBad;
    ctrlClean.renderDec = ctrlP.renderDec && !err.renderBad && !err.rotBad && !err.auxAlignBad;
    ctrlClean.mediaDec = ctrlP.mediaDec && !err.mediaBad && !err.rotBad && !err.auxAlignBad;
    ctrlClean.clearEn = ctrlP.clearEn && ctrlClean.renderDec;
  end

  // flip commit: sync waits for frame start and the shared stall unless the plane is off, so both
  // planes of a planar pair release on the same update
  wire logic planeOff = !ctrlA.enable;
  wire logic asyncPath = ctrlP.asyncEn && !err.asyncBad;
  wire logic syncCommit = armed_q && !asyncPath && ((vblankStart && !dbStall) || planeOff);
  wire logic asyncCommit = armed_q && asyncPath && (tlbBoundary || vblankStart || planeOff);

  for (genvar i = 0; i < plane_fetch_pkg::NUM_DB; i++) begin : g_db
    assign dbNext[i] = (i == int'(plane_fetch_pkg::R_CTRL)) ? 32'(ctrlClean) : pend_q[i];
    always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
        pend_q[i] <= plane_fetch_pkg::REG_RESET;
      end else if (wEn && wIdx == 4'(i)) begin
        pend_q[i] <= wMerged;
      end
    end
    always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
        act_q[i] <= plane_fetch_pkg::REG_RESET;
      end else if (syncCommit || (asyncCommit && i == int'(plane_fetch_pkg::R_SURF))) begin
        act_q[i] <= dbNext[i];
      end
    end
  end

  // arm on surface write; another buffered write while armed disarms; arming wins
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      armed_q <= 1'b0;
      flipDone <= 1'b0;
    end else begin
      armed_q <= armWrite || (armed_q && !syncCommit && !asyncCommit && !otherDbWrite);
      flipDone <= syncCommit || asyncCommit;
    end
  end

  // upsampler control is live; only UV-capable planes may enable it
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cus_q <= '0;
      upsCtl <= '0;
      postCtl <= 3'h0;
      planeCfg <= '0;
      startPend_q <= 1'b0;
    end else begin
      if (wEn && wIdx == plane_fetch_pkg::R_CUS) begin
        cus_q <= wMerged;
      end
      upsCtl <= cus_q;
      upsCtl.enable <= cus_q.enable && !err.upsBad;
      // a plane bound as Y lets the UV plane own keying, correction and gamma
      postCtl <= yRoleIn ? 3'h0 : {ctrlA.gammaEn, ctrlA.colorCorrEn, ctrlA.keyEn};
      planeCfg <= ctrlA;
      startPend_q <= vblankStart;
    end
  end

  assign planeGeom.stride = act_q[plane_fetch_pkg::R_STRIDE];
  assign planeGeom.offset = act_q[plane_fetch_pkg::R_OFFSET];
  assign planeGeom.size = act_q[plane_fetch_pkg::R_SIZE];
  assign planeGeom.surfHeight = act_q[plane_fetch_pkg::R_SHEIGHT];
  assign planeGeom.auxStride = act_q[plane_fetch_pkg::R_AUXSTRIDE];
  assign planeGeom.clearColour = act_q[plane_fetch_pkg::R_CCVAL];

  // control surface sits at the programmed distance after the main surface
  wire logic decompOn = ctrlA.renderDec || ctrlA.mediaDec;
  wire logic [31:0] csBase = decompOn
    ? 32'(act_q[plane_fetch_pkg::R_SURF] + act_q[plane_fetch_pkg::R_AUXDIST]) : 32'h00000000;

  plane_page_walker u_walk (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .start(startPend_q && ctrlA.enable),
    .rot(ctrlA.rot),
    .mediaMode(ctrlA.mediaDec),
    .base(act_q[plane_fetch_pkg::R_SURF]),
    .csBase(csBase),
    .pages(act_q[plane_fetch_pkg::R_PAGES][15:0]),
    .ready(fetchReady),
    .valid(fetchValid),
    .req(fetchReq),
    .busy(walkBusy)
  );

  // read side
  wire logic [3:0] rIdx = s_axi_araddr[5:2];
  wire logic rInRange = (s_axi_araddr[31:6] == 26'h0000000) && (rIdx <= plane_fetch_pkg::R_ID);
  wire logic [31:0] statusWord = {20'h00000, walkBusy, armed_q, err};
  wire logic [31:0] idWord = {22'h000000, FBC_PLANE, Y_PLANE, UV_PLANE, UV_PLANE, CS_NUM};
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h00000000;
    if (!rInRange) begin
      rdMux = 32'h00000000;
    end else if (rIdx < plane_fetch_pkg::R_CUS) begin
      rdMux = pend_q[rIdx];
    end else if (rIdx == plane_fetch_pkg::R_CUS) begin
      rdMux = cus_q;
    end else if (rIdx == plane_fetch_pkg::R_STATUS) begin
      rdMux = statusWord;
    end else if (rIdx == plane_fetch_pkg::R_LIVE) begin
      rdMux = act_q[plane_fetch_pkg::R_SURF];
    end else begin
      rdMux = idWord;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= plane_fetch_pkg::RESP_OKAY;
      awAddr_q <= 32'h00000000;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wInRange ? plane_fetch_pkg::RESP_OKAY : plane_fetch_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= plane_fetch_pkg::RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rdata <= rdMux;
        s_axi_rresp <= rInRange ? plane_fetch_pkg::RESP_OKAY : plane_fetch_pkg::RESP_SLVERR;
        s_axi_rvalid <= 1'b1;
        s_axi_arready <= 1'b0;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule : display_plane_yuv_decomp_fetch

// [src/plane_cap_check.sv]
/*
  Combinational legality check of one plane's programmed control word.
  Assumes PIPE (0..3) and PLANE (1..5) name the plane's position.
*/
`timescale 1ns/10ps
module plane_cap_check #(
  parameter int PIPE = 0,
  parameter int PLANE = 1
) (
  input plane_fetch_pkg::ctrl_t ctrl,
  input plane_fetch_pkg::cus_t cus,
  input wire logic [31:0] auxDist,
  output plane_fetch_pkg::cap_err_t err
);
  localparam bit UV_PLANE = (PLANE >= 1) && (PLANE <= 3);
  localparam bit FBC_PLANE = (PIPE == 0) && (PLANE == 1);
  wire logic isRgb = ctrl.fmt != plane_fetch_pkg::FMT_YUV;
  wire logic rotSide = (ctrl.rot == plane_fetch_pkg::ROT_90) || (ctrl.rot == plane_fetch_pkg::ROT_270);
  wire logic isLinear = ctrl.tile == plane_fetch_pkg::TILE_LINEAR;
  wire logic isYLike = (ctrl.tile == plane_fetch_pkg::TILE_Y) || (ctrl.tile == plane_fetch_pkg::TILE_4);
  wire logic decFmt = (ctrl.fmt == plane_fetch_pkg::FMT_RGB8888X) || (ctrl.fmt == plane_fetch_pkg::FMT_ARGB8888)
    || (ctrl.fmt == plane_fetch_pkg::FMT_RGB2101010) || (ctrl.fmt == plane_fetch_pkg::FMT_FP16);
  wire logic fbcFmt = (ctrl.fmt == plane_fetch_pkg::FMT_RGB8888X) || (ctrl.fmt == plane_fetch_pkg::FMT_RGB565);
  wire logic yBindOk = (cus.yBinding == 3'h4) || (cus.yBinding == 3'h5);

  assign err.fbcBad = ctrl.fbcEn && (!FBC_PLANE || !fbcFmt);
  assign err.asyncBad = ctrl.asyncEn && (!isRgb || ctrl.mediaDec);
  assign err.hdrBad = ctrl.hdr && !UV_PLANE;
  assign err.mirrorBad = ctrl.mirror && isLinear;
  assign err.interlaceBad = ctrl.interlace && !(isLinear || ctrl.tile == plane_fetch_pkg::TILE_X);
  assign err.rotBad = rotSide && (ctrl.interlace || ctrl.renderDec || ctrl.mediaDec);
  assign err.renderBad = ctrl.renderDec && (!isYLike || ctrl.tbPair || !decFmt);
  assign err.mediaBad = ctrl.mediaDec && (ctrl.tile != plane_fetch_pkg::TILE_Y);
  assign err.auxAlignBad = (ctrl.renderDec || ctrl.mediaDec)
    && (auxDist[11:0] != 12'h000);
  assign err.upsBad = cus.enable && (!UV_PLANE || !yBindOk);
endmodule : plane_cap_check

// [src/plane_page_walker.sv]
/*
  Cache-line address generator for one frame of a plane surface.
  Assumes remapped page tables for side rotation; the consumer may stall with ready.
*/
`timescale 1ns/10ps
module plane_page_walker (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic start,
  input plane_fetch_pkg::rot_t rot,
  input wire logic mediaMode,
  input wire logic [31:0] base,
  input wire logic [31:0] csBase,
  input wire logic [15:0] pages,
  input wire logic ready,
  output logic valid,
  output plane_fetch_pkg::fetch_t req,
  output logic busy
);
  logic [15:0] pg_q;
  logic [5:0] ln_q;
  wire logic rev = rot == plane_fetch_pkg::ROT_180;
  wire logic side = (rot == plane_fetch_pkg::ROT_90) || (rot == plane_fetch_pkg::ROT_270);
  // pages sequential for side rotation; the in-page walk runs down tile columns
  wire logic [15:0] pgEff = rev ? 16'(pages - 16'h0001 - pg_q) : pg_q;
  wire logic [5:0] lnEff = rev ? 6'(plane_fetch_pkg::LAST_LINE - ln_q)
    : (side ? {ln_q[4:0], ln_q[5]} : ln_q);
  wire logic [21:0] lineIdx = {pgEff, lnEff};
  // four bits of status per line pair, or per four-line unit in media mode
  wire logic [21:0] unitIdx = mediaMode ? {2'h0, lineIdx[21:2]} : {1'h0, lineIdx[21:1]};
  wire logic advance = busy && (!valid || ready);
  wire logic lastLine = (ln_q == plane_fetch_pkg::LAST_LINE) && (pg_q == 16'(pages - 16'h0001));

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      busy <= 1'b0;
      valid <= 1'b0;
      pg_q <= 16'h0000;
      ln_q <= 6'h00;
      req <= '0;
    end else begin
      if (start && !busy && pages != 16'h0000) begin
        busy <= 1'b1;
        valid <= valid && !ready;
        pg_q <= 16'h0000;
        ln_q <= 6'h00;
      end else if (advance) begin
        valid <= 1'b1;
        req.addr <= 32'(base + {pgEff, 12'h000} + {lnEff, 6'h00});
        req.csAddr <= 32'(csBase + {11'h000, unitIdx[21:1]});
        req.csNibble <= unitIdx[0];
        ln_q <= 6'(ln_q + 6'h01);
        if (ln_q == plane_fetch_pkg::LAST_LINE) begin
          pg_q <= 16'(pg_q + 16'h0001);
        end
        if (lastLine) begin
          busy <= 1'b0;
        end
      end else if (valid && ready) begin
        valid <= 1'b0;
      end
    end
  end
endmodule : plane_page_walker

// [testbench/display_plane_yuv_decomp_fetch_props.sv]
/* Checker for bus handshakes, fetch hold and committed control legality of one plane.
   Assumes it is bound to the plane top and given the same PIPE and PLANE. */
`timescale 1ns/10ps
module display_plane_yuv_decomp_fetch_props #(
  parameter int PIPE = 0,
  parameter int PLANE = 1
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic yRoleIn,
  input wire logic fetchReady,
  input wire logic fetchValid,
  input plane_fetch_pkg::fetch_t fetchReq,
  input plane_fetch_pkg::ctrl_t planeCfg,
  input wire logic [2:0] postCtl
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence respLater;
    ##1 !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  write_resp_delay_a: assert property (wrTaken |-> respLater) else $error("write response delay wrong");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  fetch_hold_a: assert property (fetchValid && !fetchReady |=> fetchValid && $stable(fetchReq))
    else $error("fetch request not held");
  post_mute_a: assert property (yRoleIn ##1 yRoleIn |-> postCtl == 3'h0) else $error("y plane post ctl");
  fbc_place_a: assert property (planeCfg.fbcEn |-> PIPE == 0 && PLANE == 1 &&
    planeCfg.fmt inside {plane_fetch_pkg::FMT_RGB8888X, plane_fetch_pkg::FMT_RGB565}) else $error("fbc illegal");
  async_rgb_a: assert property (planeCfg.asyncEn |-> planeCfg.fmt != plane_fetch_pkg::FMT_YUV &&
    !planeCfg.mediaDec) else $error("async illegal");
  mirror_tile_a: assert property (planeCfg.mirror |-> planeCfg.tile != plane_fetch_pkg::TILE_LINEAR)
    else $error("mirror on linear");
  render_tile_a: assert property (planeCfg.renderDec |-> !planeCfg.tbPair &&
    planeCfg.tile inside {plane_fetch_pkg::TILE_Y, plane_fetch_pkg::TILE_4}) else $error("render decomp illegal");
endmodule : display_plane_yuv_decomp_fetch_props

bind display_plane_yuv_decomp_fetch display_plane_yuv_decomp_fetch_props #(.PIPE(PIPE), .PLANE(PLANE)) props_inst (
  .ref_clk, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .yRoleIn, .fetchReady, .fetchValid,
  .fetchReq, .planeCfg, .postCtl
);

// [testbench/display_plane_yuv_decomp_fetch_tb.sv]
/* Self-checking bench of one plane: registers, legality, flips and frame walks.
   Assumes the memory partner model and the bound checker. */
`timescale 1ns/10ps
module display_plane_yuv_decomp_fetch_tb;
  localparam int PIPE = 0;
  localparam int PLANE = 1;
  localparam logic [31:0] DIST = 32'h00002000;
  logic ref_clk = 1'b0, reset_n = 1'b0, clearCount = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, a, d, e;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, fetchValid, fetchReady, flipDone;
  logic vblankStart = 1'b0, tlbBoundary = 1'b0, dbStall = 1'b0, yRoleIn = 1'b0;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [2:0] postCtl;
  logic [15:0] seed = 16'h0028;
  plane_fetch_pkg::fetch_t fetchReq, firstReq_q, lastReq_q;
  plane_fetch_pkg::ctrl_t planeCfg;
  plane_fetch_pkg::geom_t planeGeom;
  plane_fetch_pkg::cus_t upsCtl;
  int takeCount_q, fails = 0, samples_checked = 0, flips = 0;

  display_plane_yuv_decomp_fetch #(.PIPE(PIPE), .PLANE(PLANE)) display_plane_yuv_decomp_fetch_inst (
    .ref_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .vblankStart, .tlbBoundary,
    .dbStall, .yRoleIn, .fetchReady, .fetchValid, .fetchReq, .flipDone, .planeCfg, .planeGeom, .upsCtl, .postCtl
  );
  fetch_mem_model fetch_mem_model_inst (
    .ref_clk, .reset_n, .fetchValid, .fetchReq, .clearCount, .fetchReady, .takeCount_q, .firstReq_q, .lastReq_q
  );

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (flipDone === 1'b1) flips++;
  end

  function automatic logic [15:0] lfsrNext(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsrNext
  function automatic logic [31:0] idWord(input int pi, input int pl);
    logic [5:0] cs;
    cs = pi < 3 ? 6'((pl - 1) * 3 + pi + 1) : 6'(21 + pl);
    return {22'h0, pi == 0 && pl == 1, pl > 3, pl <= 3, pl <= 3, cs};
  endfunction : idWord
  // legality flags expected from a programmed control word
  function automatic logic [31:0] capErr(input logic [31:0] c);
    logic [2:0] f;
    logic [1:0] t;
    f = c[3:1];
    t = c[5:4];
    capErr = 32'h0;
    capErr[0] = c[14] && !(PIPE == 0 && PLANE == 1 && (f == 3'h1 || f == 3'h6));
    capErr[1] = c[10] && (f == 3'h7 || c[12]);
    capErr[3] = c[8] && t == 2'h0;
    capErr[4] = c[9] && t > 2'h1;
    capErr[5] = c[6] && (c[9] || c[11] || c[12]);
    capErr[6] = c[11] && (t < 2'h2 || c[19] || !(f inside {3'h0, 3'h1, 3'h2, 3'h4}));
    capErr[7] = c[12] && t != 2'h2;
  endfunction : capErr

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  task automatic hang();
    fails++;
    report_and_stop();
  endtask : hang
  task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmpWord
  task automatic axiWr(input logic [31:0] ad, input logic [31:0] v, output logic [1:0] rr);
    int n;
    @(posedge ref_clk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 64) hang();
  endtask : axiWr
  task automatic axiRd(input logic [31:0] ad, output logic [31:0] v, output logic [1:0] rr);
    int n;
    @(posedge ref_clk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    v = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 64) hang();
  endtask : axiRd
  task automatic pulseEvt(input logic tlb);
    @(posedge ref_clk);
    clearCount <= 1'b1;
    if (tlb) tlbBoundary <= 1'b1;
    else vblankStart <= 1'b1;
    @(posedge ref_clk);
    clearCount <= 1'b0;
    tlbBoundary <= 1'b0;
    vblankStart <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask : pulseEvt
  task automatic waitWalk();
    int n;
    for (n = 0; n < 3000 && takeCount_q < 128; n++) @(posedge ref_clk);
    if (n == 3000) hang();
  endtask : waitWalk
  // two pages of 64 lines, reversed order when rev is set
  task automatic checkWalk(input logic [31:0] base, input logic rev, input logic dec);
    waitWalk();
    cmpWord(firstReq_q.addr, base + (rev ? 32'h1FC0 : 32'h0));
    cmpWord(lastReq_q.addr, base + (rev ? 32'h0 : 32'h1FC0));
    if (dec) begin
      cmpWord(lastReq_q.csAddr, base + DIST + 32'h1F);
      cmpWord({31'h0, lastReq_q.csNibble}, 32'h1);
    end
  endtask : checkWalk

  initial begin
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      axiRd(32'(i * 4), d, r);
      cmpWord(d, plane_fetch_pkg::REG_RESET);
    end
    axiRd(32'h34, d, r);
    cmpWord(d, idWord(PIPE, PLANE));
    axiWr(32'h38, 32'h5A5A5A5A, r);
    cmpWord({30'h0, r}, {30'h0, plane_fetch_pkg::RESP_SLVERR});
    axiRd(32'h38, d, r);
    cmpWord({30'h0, r}, {30'h0, plane_fetch_pkg::RESP_SLVERR});
    cmpWord(d, 32'h0);
    for (int i = 0; i < 24; i++) begin
      seed = lfsrNext(seed);
      a = 32'h8 + 32'(seed[2:0]) * 4;
      e = {seed, lfsrNext(seed)};
      axiWr(a, e, r);
      axiRd(a, d, r);
      cmpWord(d, e);
    end
    $display("test reset, map and readback done");
    axiWr(32'h18, DIST, r);
    for (int i = 0; i < 20; i++) begin
      seed = lfsrNext(seed);
      e = i == 0 ? 32'h40E : i == 1 ? 32'h4008 : i == 2 ? 32'h222 : {seed, seed ^ 16'hA5A5} & 32'h85FFE;
      if (e[11]) e[12] = 1'b0;
      axiWr(32'h0, e, r);
      axiRd(32'h2C, d, r);
      cmpWord(d & 32'h3FF, capErr(e));
    end
    $display("test legality done");
    axiWr(32'h24, 32'h2, r);
    axiWr(32'h20, 32'h00FF00FF, r);
    axiWr(32'h0, 32'hA23, r);
    axiWr(32'h4, 32'h10000, r);
    pulseEvt(1'b0);
    cmpWord(planeCfg, 32'h823);
    cmpWord(planeGeom.clearColour, 32'h00FF00FF);
    checkWalk(32'h10000, 1'b0, 1'b1);
    dbStall <= 1'b1;
    axiWr(32'h0, 32'h8A3, r);
    axiWr(32'hC, 32'h00190032, r);
    axiWr(32'h4, 32'h20000, r);
    axiRd(32'h2C, d, r);
    cmpWord(d & 32'h400, 32'h400);
    e = 32'(flips);
    pulseEvt(1'b0);
    waitWalk();
    axiRd(32'h30, d, r);
    cmpWord(d, 32'h10000);
    dbStall <= 1'b0;
    pulseEvt(1'b0);
    cmpWord(32'(flips) - e, 32'h1);
    axiRd(32'h30, d, r);
    cmpWord(d, 32'h20000);
    checkWalk(32'h20000, 1'b1, 1'b0);
    $display("test walks and stalled flip done");
    axiWr(32'h0, 32'h10023, r);
    axiWr(32'h4, 32'h30000, r);
    pulseEvt(1'b0);
    waitWalk();
    dbStall <= 1'b1;
    axiWr(32'h0, 32'h10423, r);
    axiWr(32'h4, 32'h40000, r);
    pulseEvt(1'b1);
    axiRd(32'h30, d, r);
    cmpWord(d, 32'h40000);
    cmpWord({29'h0, postCtl}, 32'h1);
    yRoleIn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    cmpWord({29'h0, postCtl}, 32'h0);
    axiWr(32'h28, 32'h9, r);
    @(posedge ref_clk);
    cmpWord(upsCtl, 32'h9);
    $display("test async flip and binding done");
    report_and_stop();
  end
endmodule : display_plane_yuv_decomp_fetch_tb

// [testbench/fetch_mem_model.sv]
/* Memory side of the plane fetch: takes requests with pseudo-random stalls, records first and last.
   Assumes the plane's valid/ready request handshake on ref_clk. */
`timescale 1ns/10ps
module fetch_mem_model (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic fetchValid,
  input plane_fetch_pkg::fetch_t fetchReq,
  input wire logic clearCount,
  output logic fetchReady,
  output int takeCount_q,
  output plane_fetch_pkg::fetch_t firstReq_q,
  output plane_fetch_pkg::fetch_t lastReq_q
);
  logic [7:0] stall_q;
  always_ff @(posedge ref_clk) begin
    if (!reset_n || clearCount) begin
      takeCount_q <= 0;
    end else if (fetchValid && fetchReady) begin
      takeCount_q <= takeCount_q + 1;
      lastReq_q <= fetchReq;
      if (takeCount_q == 0) firstReq_q <= fetchReq;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!reset_n) stall_q <= 8'h5A;
    else stall_q <= {stall_q[6:0], stall_q[7] ^ stall_q[5] ^ stall_q[4] ^ stall_q[3]};
  end
  // stalls roughly one cycle in four
  assign fetchReady = reset_n && (stall_q[1:0] != 2'h0);
endmodule : fetch_mem_model
